// file: mpu_core_cfg.svh
// Constants of the core special function register bank and DIO ports.
// Assumes inclusion by bare name from the package, the bank module and the pin model.
//
// Functional notes
// - High MOVX address byte register at 0xBF, reset 0x00.
// - Baud control at 0xD8, reset 0x00, bit 7 only.
// - Interrupt request control at 0xC0, reset 0x00.
// - Status, accumulator, B reset to 0x00.
// - Accumulator holds operands, implicitly addressed by instructions.
// - B serves multiply/divide, else scratch byte.
// - Status bits: carry, half carry, user, overflow, user.
// - Status bit 0 is accumulator even parity.
// - Stack pointer resets 0x07, pre-increments on push.
// - Data pointer 16-bit, loaded whole or bytewise.
// - Program counter resets 0x0000, increments on fetch.
// - Latch one drives pin high, zero low.
// - Latch visible on pins configured as outputs.
// - Direction registers at 0xA2/0x91/0xA1, one outputs.
// - Port data 0x80/0x90/0xA0 serve pins 0-21.
// - Each port has latch, driver and input buffer.
// - Output pins stay readable through input path.
// - Registers answer only direct, never indirect, accesses.
`ifndef MPU_CORE_CFG_SVH
`define MPU_CORE_CFG_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_PORT0_DATA 8'h80
`define ADDR_STACK_POINTER 8'h81
`define ADDR_DATA_POINTER_LOW 8'h82
`define ADDR_DATA_POINTER_HIGH 8'h83
`define ADDR_PORT1_DATA 8'h90
`define ADDR_PORT1_DIRECTION 8'h91
`define ADDR_PORT2_DATA 8'hA0
`define ADDR_PORT2_DIRECTION 8'hA1
`define ADDR_PORT0_DIRECTION 8'hA2
`define ADDR_MOVX_HIGH_ADDRESS 8'hBF
`define ADDR_INTERRUPT_REQUEST_CONTROL 8'hC0
`define ADDR_PROGRAM_STATUS_WORD 8'hD0
`define ADDR_BAUD_RATE_CONTROL 8'hD8
`define ADDR_WORKING_OPERAND 8'hE0
`define ADDR_MULTIPLY_AUX 8'hF0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE_ZERO 8'h00
`define RST_PORT0_DATA 8'hFF
`define RST_PORT1_DATA 8'hFF
`define RST_PORT2_DATA 8'h00
`define RST_DIRECTION 8'h00
`define RST_STACK_POINTER 8'h07
`define RST_DATA_POINTER 16'h0000
`define RST_PROGRAM_COUNTER 16'h0000
`define RST_BANK_BASE 8'h00

// ----------------------------------------------------------------
// Status word and baud control fields
// ----------------------------------------------------------------
`define PSW_CARRY 7
`define PSW_HALF_CARRY 6
`define PSW_USER_FLAG_ZERO 5
`define PSW_BANK_HIGH 4
`define PSW_BANK_LOW 3
`define PSW_OVERFLOW 2
`define PSW_USER_FLAG_ONE 1
`define PSW_PARITY 0
`define BAUD_RATE_BIT 7
`define BANK_SHIFT 3

// ----------------------------------------------------------------
// Pins and step sizes
// ----------------------------------------------------------------
`define PORT_WIDTH 8
`define PORT2_PINS 6
`define DIO_PINS 22
`define STACK_STEP 8'h01
`define PC_STEP 16'h0001

`endif

// file: mpu_core_pkg.sv
// Types shared by the special function register bank.
// Assumes mpu_core_cfg.svh is reachable on the include path.
`include "mpu_core_cfg.svh"

package mpu_core_pkg;

    // Flag updates from the arithmetic unit
    typedef struct packed {
        logic carry_we;
        logic carry;
        logic half_carry_we;
        logic half_carry;
        logic overflow_we;
        logic overflow;
    } flag_update_t;

    // Drive of the 22 DIO pins
    typedef struct packed {
        logic [`DIO_PINS-1:0] level;
        logic [`DIO_PINS-1:0] enable;
    } pin_drive_t;

endpackage : mpu_core_pkg

// file: pin_input_sync.sv
// Three-stage input synchroniser with agreement filter for DIO pins.
// Assumes pins are asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module pin_input_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_level
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] level_r;

    // First stage feeds only the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            stage1_r <= pin_async;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // A change counts once two later stages agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            level_r <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_r[i] == stage3_r[i]) begin
                    level_r[i] <= stage3_r[i];
                end
            end
        end
    end

    assign pin_level = level_r;

endmodule : pin_input_sync

`default_nettype wire

// file: mpu_core_sfr_and_ports.sv
// Core special function registers and the three DIO ports.
// Assumes a direct-address SFR bus from the core sequencer; the
// core raises sfr_direct only for direct-addressed data accesses.
`timescale 1ns/1ps
`default_nettype none
`include "mpu_core_cfg.svh"

module mpu_core_sfr_and_ports (
    input wire logic mclk,
    input wire logic resetn,
    // SFR bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_direct,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Core datapath hooks
    input wire logic acc_load,
    input wire logic [7:0] acc_value,
    input wire logic aux_load,
    input wire logic [7:0] aux_value,
    input wire mpu_core_pkg::flag_update_t flag_update,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic data_pointer_load,
    input wire logic [15:0] data_pointer_value,
    input wire logic pc_increment,
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    // Register contents towards the core
    output logic [7:0] working_operand,
    output logic [7:0] multiply_aux,
    output logic [7:0] status_word,
    output logic [7:0] bank_base,
    output logic [7:0] stack_pointer,
    output logic [15:0] data_pointer,
    output logic [15:0] program_counter,
    output logic [7:0] movx_high_address,
    output logic [7:0] interrupt_request_control,
    output logic baud_rate_select,
    // DIO pins
    input wire logic [`DIO_PINS-1:0] digital_io_pin_in,
    output mpu_core_pkg::pin_drive_t digital_io_pin
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] acc_r;
    logic [7:0] aux_r;
    logic [7:0] psw_r;
    logic [7:0] psw_nxt;
    logic [7:0] acc_nxt;
    logic [7:0] bank_base_r;
    logic [7:0] sp_r;
    logic [15:0] data_pointer_r;
    logic [15:0] pc_r;
    logic [7:0] movx_high_r;
    logic [7:0] irq_ctrl_r;
    logic baud_bit_r;
    logic [7:0] port0_data_r;
    logic [7:0] port1_data_r;
    logic [7:0] port2_data_r;
    logic [7:0] port0_dir_r;
    logic [7:0] port1_dir_r;
    logic [7:0] port2_dir_r;
    logic [7:0] rdata_r;
    logic hit_r;
    logic [`DIO_PINS-1:0] pin_level_r;
    logic [`DIO_PINS-1:0] pin_oe_r;

    logic wr_ok;
    logic rd_ok;
    logic [7:0] port0_pins;
    logic [7:0] port1_pins;
    logic [`PORT2_PINS-1:0] port2_pins;

    // ----------------------------------------------------------------
    // Access qualification
    // ----------------------------------------------------------------
    // Indirect accesses to the upper half go to RAM, not here
    assign wr_ok = sfr_wr && sfr_direct;
    assign rd_ok = sfr_rd && sfr_direct;

    function automatic logic wr_at(input logic [7:0] addr);
        wr_at = wr_ok && (sfr_addr == addr);
    endfunction : wr_at

    // ----------------------------------------------------------------
    // Accumulator and B
    // ----------------------------------------------------------------
    // Bus write beats the datapath: an explicit MOV is the later intent
    always_comb begin
        acc_nxt = acc_r;
        if (acc_load) begin
            acc_nxt = acc_value;
        end
        if (wr_at(`ADDR_WORKING_OPERAND)) begin
            acc_nxt = sfr_wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            acc_r <= `RST_BYTE_ZERO;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            aux_r <= `RST_BYTE_ZERO;
        end else if (wr_at(`ADDR_MULTIPLY_AUX)) begin
            aux_r <= sfr_wdata;
        end else if (aux_load) begin
            aux_r <= aux_value;
        end
    end

    // ----------------------------------------------------------------
    // Program status word
    // ----------------------------------------------------------------
    always_comb begin
        psw_nxt = psw_r;
        if (flag_update.carry_we) begin
            psw_nxt[`PSW_CARRY] = flag_update.carry;
        end
        if (flag_update.half_carry_we) begin
            psw_nxt[`PSW_HALF_CARRY] = flag_update.half_carry;
        end
        if (flag_update.overflow_we) begin
            psw_nxt[`PSW_OVERFLOW] = flag_update.overflow;
        end
        if (wr_at(`ADDR_PROGRAM_STATUS_WORD)) begin
            psw_nxt = sfr_wdata;
        end
        // Parity is never writable; it tracks the next accumulator
        psw_nxt[`PSW_PARITY] = ^acc_nxt;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            psw_r <= `RST_BYTE_ZERO;
        end else begin
            psw_r <= psw_nxt;
        end
    end

    // Registered so the core sees the bank with the status word
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bank_base_r <= `RST_BANK_BASE;
        end else begin
            bank_base_r <= {3'h0, psw_nxt[`PSW_BANK_HIGH:`PSW_BANK_LOW], 3'h0};
        end
    end

    // ----------------------------------------------------------------
    // Stack pointer, data pointer, program counter
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sp_r <= `RST_STACK_POINTER;
        end else if (wr_at(`ADDR_STACK_POINTER)) begin
            sp_r <= sfr_wdata;
        end else if (stack_push) begin
            sp_r <= sp_r + `STACK_STEP;
        end else if (stack_pop) begin
            sp_r <= sp_r - `STACK_STEP;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            data_pointer_r <= `RST_DATA_POINTER;
        end else if (data_pointer_load) begin
            data_pointer_r <= data_pointer_value;
        end else begin
            if (wr_at(`ADDR_DATA_POINTER_LOW)) begin
                data_pointer_r[7:0] <= sfr_wdata;
            end
            if (wr_at(`ADDR_DATA_POINTER_HIGH)) begin
                data_pointer_r[15:8] <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pc_r <= `RST_PROGRAM_COUNTER;
        end else if (pc_load) begin
            pc_r <= pc_value;
        end else if (pc_increment) begin
            pc_r <= pc_r + `PC_STEP;
        end
    end

    // ----------------------------------------------------------------
    // Miscellaneous control registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            movx_high_r <= `RST_BYTE_ZERO;
        end else if (wr_at(`ADDR_MOVX_HIGH_ADDRESS)) begin
            movx_high_r <= sfr_wdata;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_ctrl_r <= `RST_BYTE_ZERO;
        end else if (wr_at(`ADDR_INTERRUPT_REQUEST_CONTROL)) begin
            irq_ctrl_r <= sfr_wdata;
        end
    end

    // Only one bit exists; the rest read as zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            baud_bit_r <= 1'b0;
        end else if (wr_at(`ADDR_BAUD_RATE_CONTROL)) begin
            baud_bit_r <= sfr_wdata[`BAUD_RATE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Port latches and direction
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            port0_data_r <= `RST_PORT0_DATA;
            port1_data_r <= `RST_PORT1_DATA;
            port2_data_r <= `RST_PORT2_DATA;
        end else begin
            if (wr_at(`ADDR_PORT0_DATA)) begin
                port0_data_r <= sfr_wdata;
            end
            if (wr_at(`ADDR_PORT1_DATA)) begin
                port1_data_r <= sfr_wdata;
            end
            if (wr_at(`ADDR_PORT2_DATA)) begin
                port2_data_r <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            port0_dir_r <= `RST_DIRECTION;
            port1_dir_r <= `RST_DIRECTION;
            port2_dir_r <= `RST_DIRECTION;
        end else begin
            if (wr_at(`ADDR_PORT0_DIRECTION)) begin
                port0_dir_r <= sfr_wdata;
            end
            if (wr_at(`ADDR_PORT1_DIRECTION)) begin
                port1_dir_r <= sfr_wdata;
            end
            if (wr_at(`ADDR_PORT2_DIRECTION)) begin
                port2_dir_r <= sfr_wdata;
            end
        end
    end

    // Pin drive mirrors latch and direction one edge later
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_level_r <= '0;
            pin_oe_r <= '0;
        end else begin
            pin_level_r <= {port2_data_r[`PORT2_PINS-1:0], port1_data_r,
                            port0_data_r};
            pin_oe_r <= {port2_dir_r[`PORT2_PINS-1:0], port1_dir_r,
                         port0_dir_r};
        end
    end

    // ----------------------------------------------------------------
    // Pin input path
    // ----------------------------------------------------------------
    // Always sampled, output or not, so pulses driven out stay visible
    pin_input_sync #(.WIDTH(`PORT_WIDTH)) u_sync_port0 (
        .mclk(mclk),
        .resetn(resetn),
        .pin_async(digital_io_pin_in[7:0]),
        .pin_level(port0_pins)
    );

    pin_input_sync #(.WIDTH(`PORT_WIDTH)) u_sync_port1 (
        .mclk(mclk),
        .resetn(resetn),
        .pin_async(digital_io_pin_in[15:8]),
        .pin_level(port1_pins)
    );

    pin_input_sync #(.WIDTH(`PORT2_PINS)) u_sync_port2 (
        .mclk(mclk),
        .resetn(resetn),
        .pin_async(digital_io_pin_in[21:16]),
        .pin_level(port2_pins)
    );

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unmapped addresses read zero and drop hit
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= `RST_BYTE_ZERO;
            hit_r <= 1'b0;
        end else if (rd_ok) begin
            hit_r <= 1'b1;
            case (sfr_addr)
                `ADDR_PORT0_DATA: rdata_r <= port0_pins;
                `ADDR_PORT1_DATA: rdata_r <= port1_pins;
                `ADDR_PORT2_DATA: rdata_r <= {2'h0, port2_pins};
                `ADDR_PORT0_DIRECTION: rdata_r <= port0_dir_r;
                `ADDR_PORT1_DIRECTION: rdata_r <= port1_dir_r;
                `ADDR_PORT2_DIRECTION: rdata_r <= port2_dir_r;
                `ADDR_STACK_POINTER: rdata_r <= sp_r;
                `ADDR_DATA_POINTER_LOW: rdata_r <= data_pointer_r[7:0];
                `ADDR_DATA_POINTER_HIGH: rdata_r <= data_pointer_r[15:8];
                `ADDR_MOVX_HIGH_ADDRESS: rdata_r <= movx_high_r;
                `ADDR_INTERRUPT_REQUEST_CONTROL: rdata_r <= irq_ctrl_r;
                `ADDR_PROGRAM_STATUS_WORD: rdata_r <= psw_r;
                `ADDR_BAUD_RATE_CONTROL: rdata_r <= {baud_bit_r, 7'h00};
                `ADDR_WORKING_OPERAND: rdata_r <= acc_r;
                `ADDR_MULTIPLY_AUX: rdata_r <= aux_r;
                default: begin
                    rdata_r <= `RST_BYTE_ZERO;
                    hit_r <= 1'b0;
                end
            endcase
        end else begin
            hit_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sfr_rdata = rdata_r;
    assign sfr_hit = hit_r;
    assign working_operand = acc_r;
    assign multiply_aux = aux_r;
    assign status_word = psw_r;
    assign bank_base = bank_base_r;
    assign stack_pointer = sp_r;
    assign data_pointer = data_pointer_r;
    assign program_counter = pc_r;
    assign movx_high_address = movx_high_r;
    assign interrupt_request_control = irq_ctrl_r;
    assign baud_rate_select = baud_bit_r;
    assign digital_io_pin.level = pin_level_r;
    assign digital_io_pin.enable = pin_oe_r;

endmodule : mpu_core_sfr_and_ports

`default_nettype wire

// file: mpu_core_sfr_and_ports_assertions.sv
// Checker for the SFR bank: bus answers, status fields, pointers, pins.
// Assumes binding to mpu_core_sfr_and_ports; mclk domain only.
`timescale 1ns/1ps
`default_nettype none

module mpu_core_sfr_and_ports_assertions (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_direct,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic acc_load,
    input wire logic stack_push,
    input wire logic data_pointer_load,
    input wire logic [15:0] data_pointer_value,
    input wire logic pc_increment,
    input wire logic pc_load,
    input wire logic [7:0] working_operand,
    input wire logic [7:0] status_word,
    input wire logic [7:0] bank_base,
    input wire logic [7:0] stack_pointer,
    input wire logic [15:0] data_pointer,
    input wire logic [15:0] program_counter,
    input wire mpu_core_pkg::pin_drive_t digital_io_pin
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_rd_acc;
        sfr_rd && sfr_direct && sfr_addr == 8'hE0 && !sfr_wr
            |=> sfr_hit && sfr_rdata == $past(working_operand);
    endproperty
    a_rd_acc: assert property (p_rd_acc) else $error("acc read wrong");
    property p_wr_acc;
        sfr_wr && sfr_direct && sfr_addr == 8'hE0 |=> working_operand == $past(sfr_wdata);
    endproperty
    a_wr_acc: assert property (p_wr_acc) else $error("acc write lost");
    property p_indirect_rd;
        sfr_rd && !sfr_direct |=> !sfr_hit && $stable(sfr_rdata);
    endproperty
    a_indirect_rd: assert property (p_indirect_rd) else $error("indirect read answered");
    property p_indirect_wr;
        sfr_wr && !sfr_direct && !acc_load |=> $stable(working_operand);
    endproperty
    a_indirect_wr: assert property (p_indirect_wr) else $error("indirect write taken");
    property p_parity;
        status_word[0] == ^working_operand;
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");
    property p_bank;
        bank_base == {3'b000, status_word[4:3], 3'b000};
    endproperty
    a_bank: assert property (p_bank) else $error("bank base wrong");
    property p_push;
        stack_push && !(sfr_wr && sfr_direct && sfr_addr == 8'h81)
            |=> stack_pointer == $past(stack_pointer) + 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_data_pointer;
        data_pointer_load |=> data_pointer == $past(data_pointer_value);
    endproperty
    a_data_pointer: assert property (p_data_pointer) else $error("pointer load wrong");
    property p_pc;
        pc_increment && !pc_load |=> program_counter == $past(program_counter) + 16'h0001;
    endproperty
    a_pc: assert property (p_pc) else $error("pc step wrong");
    sequence s_wr_p0;
        sfr_wr && sfr_direct && sfr_addr == 8'h80;
    endsequence
    property p_pin0;
        s_wr_p0 ##1 !(sfr_wr && sfr_direct && sfr_addr == 8'h80)
            |=> digital_io_pin.level[7:0] == $past(sfr_wdata, 2);
    endproperty
    a_pin0: assert property (p_pin0) else $error("port0 pins wrong");

    c_push: cover property (stack_push);
    c_hit: cover property (sfr_hit);
    c_pin0: cover property (s_wr_p0);
endmodule : mpu_core_sfr_and_ports_assertions

bind mpu_core_sfr_and_ports mpu_core_sfr_and_ports_assertions i_chk (.*);
`default_nettype wire

// file: dio_pin_model.sv
// Board side of the 22 DIO pins: drives inputs, sees device outputs.
// Assumes the bench never drives a pin the device enables.
`timescale 1ns/1ps
`default_nettype none
`include "mpu_core_cfg.svh"

module dio_pin_model (
    input wire logic mclk,
    input wire mpu_core_pkg::pin_drive_t drive,
    input wire logic [`DIO_PINS-1:0] ext_level,
    input wire logic [`DIO_PINS-1:0] ext_en,
    output logic [`DIO_PINS-1:0] pin
);
    // Undriven pins toggle so a stale value never reads as good
    logic [`DIO_PINS-1:0] idle_r = 22'h155555;
    always_ff @(posedge mclk) begin
        idle_r <= ~idle_r;
    end
    assign pin = (drive.enable & drive.level) | (~drive.enable & ext_en & ext_level)
        | (~drive.enable & ~ext_en & idle_r);
endmodule : dio_pin_model
`default_nettype wire

// file: mpu_core_sfr_and_ports_tb_top.sv
// Self-checking bench for the SFR bank and DIO ports.
// Assumes dio_pin_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none

module mpu_core_sfr_and_ports_tb_top;
    logic mclk = 1'b0, resetn = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, acc_value = 8'h00, aux_value = 8'h00;
    logic sfr_direct = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, acc_load = 1'b0, aux_load = 1'b0;
    logic stack_push = 1'b0, stack_pop = 1'b0, data_pointer_load = 1'b0;
    logic pc_increment = 1'b0, pc_load = 1'b0;
    logic [15:0] data_pointer_value = 16'h0000, pc_value = 16'h0000;
    mpu_core_pkg::flag_update_t flag_update = '0;
    logic [7:0] sfr_rdata, working_operand, multiply_aux, status_word, bank_base;
    logic [7:0] stack_pointer, movx_high_address, interrupt_request_control;
    logic [15:0] data_pointer, program_counter;
    logic baud_rate_select, sfr_hit;
    logic [21:0] digital_io_pin_in, ext_level = 22'h03C3C3, ext_en = 22'h000000;
    mpu_core_pkg::pin_drive_t digital_io_pin;
    int fail_count = 0, num_checks = 0;
    logic [7:0] dat_a[3] = '{8'h80, 8'h90, 8'hA0};
    logic [7:0] dir_a[3] = '{8'hA2, 8'h91, 8'hA1};
    logic [7:0] msk[3] = '{8'hFF, 8'hFF, 8'h3F};

    initial forever #12.5 mclk = ~mclk;

    mpu_core_sfr_and_ports i_dut (
        .mclk, .resetn, .sfr_addr, .sfr_direct, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .sfr_hit, .acc_load, .acc_value, .aux_load, .aux_value, .flag_update, .stack_push,
        .stack_pop, .data_pointer_load, .data_pointer_value, .pc_increment, .pc_load, .pc_value,
        .working_operand, .multiply_aux, .status_word, .bank_base, .stack_pointer,
        .data_pointer, .program_counter, .movx_high_address, .interrupt_request_control,
        .baud_rate_select, .digital_io_pin_in, .digital_io_pin
    );
    dio_pin_model i_pins (.mclk, .drive(digital_io_pin), .ext_level, .ext_en,
        .pin(digital_io_pin_in));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One bus cycle; rdata and hit are settled when it returns
    task automatic sfr_op(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          input logic dir);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_direct = dir;
        sfr_wr = wr;
        sfr_rd = !wr;
        @(negedge mclk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask : sfr_op

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_op(1'b1, a, d, 1'b1);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_op(1'b0, a, 8'h00, 1'b1);
        check(sfr_rdata, exp);
        check(sfr_hit, 1'b1);
    endtask : rd_chk

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    initial begin
        #(25 * 20000);
        fail_count++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        rd_chk(8'hBF, 8'h00);
        rd_chk(8'hC0, 8'h00);
        rd_chk(8'hD8, 8'h00);
        rd_chk(8'hD0, 8'h00);
        rd_chk(8'hE0, 8'h00);
        rd_chk(8'hF0, 8'h00);
        rd_chk(8'h81, 8'h07);
        check(program_counter, 16'h0000);
        check(digital_io_pin.enable, 22'h000000);
        $display("test reset values done");

        wr(8'hE0, 8'h07);
        check(status_word[0], 1'b1);
        wr(8'hE0, 8'h96);
        wr(8'hD0, 8'hFF);
        rd_chk(8'hD0, 8'hFE);
        for (int i = 0; i < 4; i++) begin
            wr(8'hD0, 8'(i << 3));
            check(bank_base, 8'(i * 8));
        end
        @(negedge mclk) flag_update = '1;
        @(negedge mclk) flag_update = '0;
        check(status_word, 8'hDC);
        wr(8'hF0, 8'hA5);
        rd_chk(8'hF0, 8'hA5);
        @(negedge mclk) {aux_load, aux_value} = {1'b1, 8'h3C};
        @(negedge mclk) aux_load = 1'b0;
        check(multiply_aux, 8'h3C);
        wr(8'hD8, 8'h80);
        check(baud_rate_select, 1'b1);
        wr(8'hBF, 8'h12);
        check(movx_high_address, 8'h12);
        wr(8'hC0, 8'h5A);
        check(interrupt_request_control, 8'h5A);
        $display("test core registers done");

        @(negedge mclk) {stack_push, acc_load, acc_value} = {2'b11, 8'h01};
        @(negedge mclk) {stack_push, acc_load} = 2'b00;
        check({stack_pointer, working_operand}, {8'h08, 8'h01});
        @(negedge mclk) {data_pointer_load, data_pointer_value} = {1'b1, 16'h1234};
        @(negedge mclk) data_pointer_load = 1'b0;
        wr(8'h82, 8'hCD);
        check(data_pointer, 16'h12CD);
        wr(8'h83, 8'hAB);
        check(data_pointer, 16'hABCD);
        @(negedge mclk) pc_increment = 1'b1;
        repeat (3) @(negedge mclk);
        pc_increment = 1'b0;
        check(program_counter, 16'h0003);
        $display("test pointers done");

        sfr_op(1'b1, 8'hE0, 8'h11, 1'b0);
        check(working_operand, 8'h01);
        sfr_op(1'b0, 8'hE0, 8'h00, 1'b0);
        check(sfr_hit, 1'b0);
        sfr_op(1'b0, 8'h84, 8'h00, 1'b1);
        check(sfr_hit, 1'b0);
        rd_chk(8'hE0, 8'h01);
        $display("test addressing done");

        foreach (dat_a[p]) begin
            wr(dir_a[p], 8'hFF);
            wr(dat_a[p], 8'h5A);
        end
        @(negedge mclk);
        check(digital_io_pin.enable, 22'h3FFFFF);
        check(digital_io_pin.level, 22'h1A5A5A);
        repeat (6) @(negedge mclk);
        foreach (dat_a[p]) rd_chk(dat_a[p], 8'h5A & msk[p]);
        foreach (dat_a[p]) wr(dir_a[p], 8'h00);
        @(negedge mclk) ext_en = 22'h3FFFFF;
        repeat (6) @(negedge mclk);
        foreach (dat_a[p]) rd_chk(dat_a[p], 8'hC3 & msk[p]);
        $display("test ports done");

        @(negedge mclk) resetn = 1'b0;
        @(negedge mclk);
        check(stack_pointer, 8'h07);
        check(working_operand, 8'h00);
        check(digital_io_pin.enable, 22'h000000);
        resetn = 1'b1;
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule : mpu_core_sfr_and_ports_tb_top
`default_nettype wire
